// [core/reader_port_pkg.sv]
// Constants shared by the device end and the host end of the reader port.
// Assumes a single 100 MHz clock on both ends.
package reader_port_pkg;
    localparam int          CLK_HZ       = 100000000;
    localparam int          LINE_COUNT   = 4;
    localparam int          RATE_W       = 3;
    // Rate codes in ascending order
    localparam logic [2:0]  RATE_9600    = 3'h0;
    localparam logic [2:0]  RATE_19200   = 3'h1;
    localparam logic [2:0]  RATE_38400   = 3'h2;
    localparam logic [2:0]  RATE_115200  = 3'h3;
    localparam logic [2:0]  RATE_230400  = 3'h4;
    localparam logic [2:0]  RATE_460800  = 3'h5;
    localparam logic [2:0]  RATE_921600  = 3'h6;
    localparam logic [2:0]  RATE_DEFAULT = RATE_115200;
    localparam logic [3:0]  DIR_RESET    = 4'h0;   // All lines inputs
    localparam logic [3:0]  OUT_RESET    = 4'h0;
    localparam int          BURST_BYTES  = 256;
    localparam int          RESET_MS     = 50;
    localparam int          RESET_CYCLES = RESET_MS * (CLK_HZ / 1000);
    localparam int          DIV_W        = 14;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} serial_state_type;

    // Cycles per bit for a rate code; unused code falls back to default
    function automatic logic [13:0] bit_cycles(input logic [2:0] code);
        unique case (code)
            RATE_9600:   bit_cycles = 14'(CLK_HZ / 9600);
            RATE_19200:  bit_cycles = 14'(CLK_HZ / 19200);
            RATE_38400:  bit_cycles = 14'(CLK_HZ / 38400);
            RATE_230400: bit_cycles = 14'(CLK_HZ / 230400);
            RATE_460800: bit_cycles = 14'(CLK_HZ / 460800);
            RATE_921600: bit_cycles = 14'(CLK_HZ / 921600);
            default:     bit_cycles = 14'(CLK_HZ / 115200);
        endcase
    endfunction
endpackage

// [core/reader_port_if.sv]
// Link between the reader device and its host: serial pair, enable, four lines.
// Assumes both ends share ref_clk_i; the wire level of each line is resolved here.
`timescale 1ns/1ps
interface reader_port_if;
    logic       host_to_dev;   // Device serial input
    logic       dev_to_host;   // Device serial output
    logic       enable;        // High keeps device running
    logic [3:0] dev_line_o;
    logic [3:0] dev_line_oe;
    logic [3:0] host_line_o;
    logic [3:0] host_line_oe;
    logic [3:0] line_level;

    // Wire level: device drive, else host drive, else weak pull-down
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dev_line_oe[i]) begin
                line_level[i] = dev_line_o[i];
            end else if (host_line_oe[i]) begin
                line_level[i] = host_line_o[i];
            end else begin
                line_level[i] = 1'b0;
            end
        end
    end

    modport device (input host_to_dev, input enable, input line_level,
                    output dev_to_host, output dev_line_o, output dev_line_oe);
    modport host   (input dev_to_host, input line_level,
                    output host_to_dev, output enable, output host_line_o, output host_line_oe);
endinterface

// [core/serial_engine.sv]
// Byte transmitter and receiver with run-time selectable bit rate.
// Assumes rx_i is already synchronised by the caller.
`timescale 1ns/1ps
module serial_engine (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [2:0] rate_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    output logic            tx_o,
    input  wire logic       rx_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o
);
    logic [13:0]                        period;
    reader_port_pkg::serial_state_type  tx_state;
    logic [13:0]                        tx_cnt;
    logic [2:0]                         tx_bit;
    logic [7:0]                         tx_shift;
    reader_port_pkg::serial_state_type  rx_state;
    logic [13:0]                        rx_cnt;
    logic [2:0]                         rx_bit;
    logic [7:0]                         rx_shift;

    assign period     = reader_port_pkg::bit_cycles(rate_i);
    assign tx_ready_o = (tx_state == reader_port_pkg::ST_IDLE);

    // ************************************************************
    // Transmitter: start low, eight bits LSB first, stop high
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_state <= reader_port_pkg::ST_IDLE;
            tx_cnt   <= 14'h0000;
            tx_bit   <= 3'h0;
            tx_shift <= 8'h00;
            tx_o     <= 1'b1;
        end else begin
            unique case (tx_state)
                reader_port_pkg::ST_IDLE: begin
                    tx_o <= 1'b1;
                    if (tx_valid_i) begin
                        tx_shift <= tx_data_i;
                        tx_o     <= 1'b0;
                        tx_cnt   <= period - 14'h0001;
                        tx_state <= reader_port_pkg::ST_START;
                    end
                end
                reader_port_pkg::ST_START, reader_port_pkg::ST_DATA: begin
                    if (tx_cnt != 14'h0000) begin
                        tx_cnt <= tx_cnt - 14'h0001;
                    end else begin
                        tx_cnt <= period - 14'h0001;
                        if (tx_state == reader_port_pkg::ST_START) begin
                            tx_bit   <= 3'h0;
                            tx_o     <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_state <= reader_port_pkg::ST_DATA;
                        end else if (tx_bit == 3'h7) begin
                            tx_o     <= 1'b1;
                            tx_state <= reader_port_pkg::ST_STOP;
                        end else begin
                            tx_bit   <= tx_bit + 3'h1;
                            tx_o     <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                        end
                    end
                end
                reader_port_pkg::ST_STOP: begin
                    if (tx_cnt != 14'h0000) begin
                        tx_cnt <= tx_cnt - 14'h0001;
                    end else begin
                        tx_state <= reader_port_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Receiver: samples each bit at its centre
    // ************************************************************
    // Centre sampling keeps about half a bit of margin for rate error
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_state   <= reader_port_pkg::ST_IDLE;
            rx_cnt     <= 14'h0000;
            rx_bit     <= 3'h0;
            rx_shift   <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_data_o  <= 8'h00;
        end else begin
            rx_valid_o <= 1'b0;
            unique case (rx_state)
                reader_port_pkg::ST_IDLE: begin
                    if (!rx_i) begin
                        rx_cnt   <= {1'b0, period[13:1]};
                        rx_state <= reader_port_pkg::ST_START;
                    end
                end
                reader_port_pkg::ST_START: begin
                    if (rx_cnt != 14'h0000) begin
                        rx_cnt <= rx_cnt - 14'h0001;
                    end else if (rx_i) begin
                        rx_state <= reader_port_pkg::ST_IDLE;    // Glitch, not a start bit
                    end else begin
                        rx_cnt   <= period - 14'h0001;
                        rx_bit   <= 3'h0;
                        rx_state <= reader_port_pkg::ST_DATA;
                    end
                end
                reader_port_pkg::ST_DATA: begin
                    if (rx_cnt != 14'h0000) begin
                        rx_cnt <= rx_cnt - 14'h0001;
                    end else begin
                        rx_cnt   <= period - 14'h0001;
                        rx_shift <= {rx_i, rx_shift[7:1]};
                        rx_bit   <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) begin
                            rx_state <= reader_port_pkg::ST_STOP;
                        end
                    end
                end
                reader_port_pkg::ST_STOP: begin
                    if (rx_cnt != 14'h0000) begin
                        rx_cnt <= rx_cnt - 14'h0001;
                    end else begin
                        // Bad stop bit drops the byte
                        if (rx_i) begin
                            rx_valid_o <= 1'b1;
                            rx_data_o  <= rx_shift;
                        end
                        rx_state <= reader_port_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // serial_engine

// [core/reader_device_end.sv]
// Device end: serial port, four direction-controlled lines, enable shutdown.
// Assumes a host on reader_port_if; pin inputs pass a three-flop synchroniser and a filter register.
`timescale 1ns/1ps
module reader_device_end (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    reader_port_if.device   port,
    input  wire logic [3:0] set_direction_i,   // Per line, 1 = output
    input  wire logic [3:0] direction_mask_i,  // Lines whose direction to change
    input  wire logic       direction_write_i,
    input  wire logic [3:0] drive_output_levels_i,
    input  wire logic       drive_write_i,
    output logic [3:0]      read_input_levels_o,
    output logic [3:0]      direction_o,
    input  wire logic [2:0] select_rate_i,
    input  wire logic       rate_write_i,
    input  wire logic       save_rate_i,
    output logic [2:0]      rate_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            running_o
);
    logic [2:0]  en_sync;
    logic [2:0]  rx_sync;
    logic [2:0]  line_sync [4];
    logic        running;
    logic        rx_clean;
    logic [3:0]  line_clean;
    logic [2:0]  saved_rate;
    logic        engine_rst;
    logic        tx_ready;
    logic        tx_line;

    // ************************************************************
    // Pin synchronisers: output follows when the last two stages agree
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_sync <= 3'h0;
            rx_sync <= 3'h7;
            running <= 1'b0;
            rx_clean <= 1'b1;
        end else begin
            en_sync <= {en_sync[1:0], port.enable};
            rx_sync <= {rx_sync[1:0], port.host_to_dev};
            if (en_sync[1] == en_sync[2]) begin
                running <= en_sync[2];
            end
            if (rx_sync[1] == rx_sync[2]) begin
                rx_clean <= rx_sync[2];
            end
        end
    end

    generate
        for (genvar g = 0; g < reader_port_pkg::LINE_COUNT; g++) begin : g_line
            always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    line_sync[g]  <= 3'h0;
                    line_clean[g] <= 1'b0;
                end else begin
                    line_sync[g] <= {line_sync[g][1:0], port.line_level[g]};
                    if (line_sync[g][1] == line_sync[g][2]) begin
                        line_clean[g] <= line_sync[g][2];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Line direction and output levels
    // ************************************************************
    // Shutdown returns every line to input, as at power-up
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            direction_o <= reader_port_pkg::DIR_RESET;
        end else if (!running) begin
            direction_o <= reader_port_pkg::DIR_RESET;
        end else if (direction_write_i) begin
            direction_o <= (direction_o & ~direction_mask_i)
                         | (set_direction_i & direction_mask_i);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port.dev_line_o <= reader_port_pkg::OUT_RESET;
        end else if (!running) begin
            port.dev_line_o <= reader_port_pkg::OUT_RESET;
        end else if (drive_write_i) begin
            port.dev_line_o <= drive_output_levels_i;
        end
    end

    assign port.dev_line_oe = direction_o;

    // Input lines report pin level, output lines read as zero
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            read_input_levels_o <= 4'h0;
        end else begin
            read_input_levels_o <= line_clean & ~direction_o;
        end
    end

    // ************************************************************
    // Bit rate: live choice and the copy kept across shutdown
    // ************************************************************
    // saved_rate models retained storage: only sys_rst_i (first power) resets it, to RATE_DEFAULT
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            saved_rate <= reader_port_pkg::RATE_DEFAULT;
        end else if (running && save_rate_i) begin
            saved_rate <= rate_o;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rate_o <= reader_port_pkg::RATE_DEFAULT;
        end else if (!running) begin
            rate_o <= saved_rate;
        end else if (rate_write_i && select_rate_i <= reader_port_pkg::RATE_921600) begin
            rate_o <= select_rate_i;
        end
    end

    // ************************************************************
    // Serial engine, held in reset while shut down
    // ************************************************************
    assign engine_rst = sys_rst_i | ~running;

    serial_engine u_serial (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (engine_rst),
        .rate_i     (rate_o),
        .tx_valid_i (tx_valid_i & running),
        .tx_data_i  (tx_data_i),
        .tx_ready_o (tx_ready),
        .tx_o       (tx_line),
        .rx_i       (rx_clean),
        .rx_valid_o (rx_valid_o),
        .rx_data_o  (rx_data_o)
    );

    // No flow control: only the two data wires cross the link
    assign port.dev_to_host = tx_line;
    assign tx_ready_o       = tx_ready & running;
    assign running_o        = running;
endmodule // reader_device_end

// [core/reader_host_end.sv]
// Host end: drives enable and serial input, sets and senses the four lines.
// Assumes the device end on reader_port_if and the same 100 MHz clock.
`timescale 1ns/1ps
module reader_host_end #(
    parameter int RESET_CYCLES = reader_port_pkg::RESET_CYCLES
) (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    reader_port_if.host     port,
    input  wire logic       reset_device_i,   // Pulse: run a timed enable-low reset
    input  wire logic       power_off_i,      // Level: keep device shut down
    input  wire logic [2:0] rate_i,
    input  wire logic [3:0] host_drive_i,
    input  wire logic [3:0] host_drive_en_i,
    output logic [3:0]      line_levels_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            resetting_o
);
    logic [31:0] hold_cnt;
    logic        enable;
    logic [2:0]  rx_sync;
    logic        rx_clean;
    logic [2:0]  line_sync [4];
    logic        tx_line;
    logic        tx_ready;

    // ************************************************************
    // Enable: timed low pulse returns the device lines to defaults and its rate to the saved copy
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_cnt <= 32'h0000_0000;
        end else if (reset_device_i && hold_cnt == 32'h0000_0000) begin
            hold_cnt <= 32'(RESET_CYCLES);
        end else if (hold_cnt != 32'h0000_0000) begin
            hold_cnt <= hold_cnt - 32'h0000_0001;
        end
    end

    assign enable      = ~power_off_i && (hold_cnt == 32'h0000_0000);
    assign resetting_o = (hold_cnt != 32'h0000_0000);
    assign port.enable = enable;

    // Serial input forced low while device is off or switching
    assign port.host_to_dev = enable ? tx_line : 1'b0;

    // Lines driven low by the host while device is off
    assign port.host_line_oe = enable ? host_drive_en_i : 4'hF;
    assign port.host_line_o  = enable ? host_drive_i : 4'h0;

    // ************************************************************
    // Synchronisers for inputs from the device
    // ************************************************************
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_sync  <= 3'h7;
            rx_clean <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], port.dev_to_host};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_clean <= rx_sync[2];
            end
        end
    end

    generate
        for (genvar g = 0; g < reader_port_pkg::LINE_COUNT; g++) begin : g_line
            always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    line_sync[g]     <= 3'h0;
                    line_levels_o[g] <= 1'b0;
                end else begin
                    line_sync[g] <= {line_sync[g][1:0], port.line_level[g]};
                    if (line_sync[g][1] == line_sync[g][2]) begin
                        line_levels_o[g] <= line_sync[g][2];
                    end
                end
            end
        end
    endgenerate

    // Receiver must take every byte at once: no pacing exists
    serial_engine u_serial (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rate_i     (rate_i),
        .tx_valid_i (tx_valid_i & enable),
        .tx_data_i  (tx_data_i),
        .tx_ready_o (tx_ready),
        .tx_o       (tx_line),
        .rx_i       (rx_clean),
        .rx_valid_o (rx_valid_o),
        .rx_data_o  (rx_data_o)
    );

    assign tx_ready_o = tx_ready & enable;
endmodule // reader_host_end

// [verif/reader_host_uart_gpio_port_checker.sv]
// Checker on the wires that join the host end and the device end.
// Assumes one clock; the bench places it beside reader_port_if.
`timescale 1ns/1ps
module reader_host_uart_gpio_port_checker #(
    parameter int RESET_CYCLES = 50
) (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       host_to_dev,
    input  wire logic       dev_to_host,
    input  wire logic       enable,
    input  wire logic [3:0] dev_line_o,
    input  wire logic [3:0] dev_line_oe,
    input  wire logic [3:0] host_line_o,
    input  wire logic [3:0] host_line_oe
);
    // ****
    // Helper counters
    // ****
    logic [7:0]  h_low;
    logic [7:0]  d_low;
    logic [31:0] off_cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Low run per serial line; FF marks a run begun while disabled, which is not judged
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            h_low <= 8'hFF;
            d_low <= 8'hFF;
        end else begin
            h_low <= (!enable || (h_low == 8'hFF && !host_to_dev)) ? 8'hFF : host_to_dev ? 8'h00 : h_low + 8'h01;
            d_low <= (!enable || (d_low == 8'hFF && !dev_to_host)) ? 8'hFF : dev_to_host ? 8'h00 : d_low + 8'h01;
        end
    end
    // Length of each enable-low phase
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            off_cnt <= 32'h0;
        end else begin
            off_cnt <= enable ? 32'h0 : off_cnt + 32'h1;
        end
    end
    // ****
    // Properties
    // ****
    property p_dir_off; !enable [*6] |-> dev_line_oe == 4'h0; endproperty
    a_dir_off: assert property (p_dir_off) else $error("line driven while shut down");
    property p_out_off; !enable [*6] |-> dev_line_o == 4'h0; endproperty
    a_out_off: assert property (p_out_off) else $error("output level kept while shut down");
    property p_dir_rise; (dev_line_oe & ~$past(dev_line_oe)) != 4'h0 |-> enable && $past(enable, 3); endproperty
    a_dir_rise: assert property (p_dir_rise) else $error("line turned output while not running");
    property p_host_rx; !enable [*3] |-> !host_to_dev; endproperty
    a_host_rx: assert property (p_host_rx) else $error("serial input high while device off");
    property p_host_ln; !enable [*3] |-> (host_line_o & host_line_oe) == 4'h0; endproperty
    a_host_ln: assert property (p_host_ln) else $error("host drives a line high while device off");
    property p_host_bit; $rose(host_to_dev) |-> h_low >= 8'h6C; endproperty
    a_host_bit: assert property (p_host_bit) else $error("host low run shorter than one bit");
    property p_dev_bit; $rose(dev_to_host) |-> d_low >= 8'h6C; endproperty
    a_dev_bit: assert property (p_dev_bit) else $error("device low run shorter than one bit");
    property p_off_len; $rose(enable) |-> off_cnt >= RESET_CYCLES; endproperty
    a_off_len: assert property (p_off_len) else $error("enable low phase too short");
endmodule // reader_host_uart_gpio_port_checker

// [verif/reader_host_uart_gpio_port_tb.sv]
// Bench joining host end and device end through the port interface.
// Assumes the checker watches the wires; no model of either end is added.
`timescale 1ns/1ps
module reader_host_uart_gpio_port_tb;
    localparam int RST = 50;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [3:0]  set_dir = 4'h0, dir_mask = 4'h0, drv = 4'h0, h_drv = 4'hF, h_en = 4'h0, exp_dir, rin, dir_o, h_lv;
    logic [2:0]  sel_rate = 3'h3, h_rate = 3'h3, rate_o;
    logic        dir_wr = 1'b0, drv_wr = 1'b0, rate_wr = 1'b0, save = 1'b0, rst_dev = 1'b0, poff = 1'b0;
    logic        d_v = 1'b0, h_v = 1'b0, d_rdy, h_rdy, d_rv, h_rv, run, resetting;
    logic [7:0]  d_d = 8'h00, h_d = 8'h00, d_rd, h_rd;
    logic [7:0]  q_dev[$], q_host[$];
    logic [31:0] seed = 32'h6E19;
    int          err_total = 0, cmp_count = 0;
    int          rates[7] = '{9600, 19200, 38400, 115200, 230400, 460800, 921600};
    always #5 ref_clk_i = ~ref_clk_i;
    // ****
    // Both ends and the wire checker
    // ****
    reader_port_if reader_port_if_i ();
    reader_device_end reader_device_end_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .port(reader_port_if_i),
        .set_direction_i(set_dir), .direction_mask_i(dir_mask), .direction_write_i(dir_wr),
        .drive_output_levels_i(drv), .drive_write_i(drv_wr), .read_input_levels_o(rin), .direction_o(dir_o),
        .select_rate_i(sel_rate), .rate_write_i(rate_wr), .save_rate_i(save), .rate_o(rate_o), .tx_valid_i(d_v),
        .tx_data_i(d_d), .tx_ready_o(d_rdy), .rx_valid_o(d_rv), .rx_data_o(d_rd), .running_o(run));
    reader_host_end #(.RESET_CYCLES(RST)) reader_host_end_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .port(reader_port_if_i), .reset_device_i(rst_dev), .power_off_i(poff), .rate_i(h_rate),
        .host_drive_i(h_drv), .host_drive_en_i(h_en), .line_levels_o(h_lv), .tx_valid_i(h_v), .tx_data_i(h_d),
        .tx_ready_o(h_rdy), .rx_valid_o(h_rv), .rx_data_o(h_rd), .resetting_o(resetting));
    reader_host_uart_gpio_port_checker #(.RESET_CYCLES(RST)) reader_host_uart_gpio_port_checker_i (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .host_to_dev(reader_port_if_i.host_to_dev),
        .dev_to_host(reader_port_if_i.dev_to_host), .enable(reader_port_if_i.enable),
        .dev_line_o(reader_port_if_i.dev_line_o), .dev_line_oe(reader_port_if_i.dev_line_oe),
        .host_line_o(reader_port_if_i.host_line_o), .host_line_oe(reader_port_if_i.host_line_oe));
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A wait that runs out is a mismatch and ends the run
    task automatic wait_run(input logic v, input int lim);
        for (int i = 0; i < lim && run !== v; i++) tick(1);
        if (run !== v) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic set_rate(input logic [2:0] c, input logic [2:0] e);
        sel_rate = c;
        h_rate = e;
        rate_wr = 1'b1;
        tick(1);
        rate_wr = 1'b0;
        cmp(rate_o, e);
    endtask
    // One random byte each way at once; the queues hold what each receiver owes
    task automatic xfer(input logic [2:0] c);
        int n;
        n = reader_port_pkg::CLK_HZ / rates[c];
        set_rate(c, c);
        d_d = 8'(rnd());
        h_d = 8'(rnd());
        q_host.push_back(d_d);
        q_dev.push_back(h_d);
        d_v = 1'b1;
        h_v = 1'b1;
        tick(1);
        d_v = 1'b0;
        h_v = 1'b0;
        cmp({h_rdy, d_rdy}, 8'h00);
        cmp(reader_port_if_i.dev_to_host, 8'h00);
        tick(n + n / 2);
        cmp(reader_port_if_i.dev_to_host, d_d[0]);
        for (int i = 0; i < 12 * n && q_dev.size() + q_host.size() > 0; i++) tick(1);
        if (q_dev.size() + q_host.size() > 0) begin
            err_total++;
            tally_and_finish();
        end
        tick(n);
        cmp({h_rdy, d_rdy}, 8'h03);
    endtask
    // Receivers: each arriving byte is matched with its oldest note
    always @(posedge ref_clk_i) begin
        if (d_rv === 1'b1) cmp(d_rd, q_dev.pop_front());
        if (h_rv === 1'b1) cmp(h_rd, q_host.pop_front());
    end
    // ****
    // Main sequence
    // ****
    initial begin
        tick(16);
        sys_rst_i = 1'b0;
        wait_run(1'b1, 20);
        cmp(dir_o, 4'h0);
        cmp(rin, 4'h0);
        cmp(rate_o, reader_port_pkg::RATE_DEFAULT);
        exp_dir = 4'h0;
        for (int i = 0; i < 8; i++) begin
            dir_mask = 4'h1 << (i % 4);
            set_dir = 4'(rnd());
            exp_dir[i % 4] = set_dir[i % 4];
            dir_wr = 1'b1;
            drv = 4'(rnd());
            drv_wr = 1'b1;
            h_drv = 4'(rnd());
            h_en = ~exp_dir;
            tick(1);
            dir_wr = 1'b0;
            drv_wr = 1'b0;
            cmp(dir_o, exp_dir);
            tick(8);
            cmp(h_lv, (drv & exp_dir) | (h_drv & ~exp_dir));
            cmp(rin, h_drv & ~exp_dir);
        end
        for (int c = 0; c < 4; c++) set_rate((c < 3) ? 3'(c) : 3'h7, (c < 3) ? 3'(c) : 3'h2);
        for (int c = 3; c < 7; c++) xfer(3'(c));
        // Saved rate must survive a timed enable-low reset
        set_rate(3'h5, 3'h5);
        save = 1'b1;
        tick(1);
        save = 1'b0;
        set_rate(3'h6, 3'h6);
        rst_dev = 1'b1;
        tick(1);
        rst_dev = 1'b0;
        cmp(resetting, 8'h01);
        wait_run(1'b0, 20);
        wait_run(1'b1, RST + 40);
        cmp(rate_o, 3'h5);
        cmp(dir_o, 4'h0);
        poff = 1'b1;
        wait_run(1'b0, 20);
        set_dir = 4'hF;
        dir_mask = 4'hF;
        dir_wr = 1'b1;
        tick(1);
        dir_wr = 1'b0;
        cmp(dir_o, 4'h0);
        tick(RST);
        poff = 1'b0;
        wait_run(1'b1, 40);
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        wait_run(1'b1, 20);
        cmp(rate_o, reader_port_pkg::RATE_DEFAULT);
        tally_and_finish();
    end
endmodule // reader_host_uart_gpio_port_tb
